// *** common/sru_params.svh ***
// Constants for the serial receive unit: register offsets, bit positions,
// reset values and sampling figures. Included by the package and the bench.
`ifndef SRU_PARAMS_SVH
`define SRU_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SRU_AW 3
`define SRU_OFS_DATA 3'h0
`define SRU_OFS_CSRA 3'h1
`define SRU_OFS_CSRB 3'h2
`define SRU_OFS_CSRC 3'h3
`define SRU_OFS_BAUD 3'h4

// ****************************************************************
// Bit positions
// ****************************************************************
`define SRU_A_RXC 7
`define SRU_A_FE 4
`define SRU_A_DOR 3
`define SRU_A_PE 2
`define SRU_A_U2X 1
`define SRU_B_RXCIE 7
`define SRU_B_RXEN 4
`define SRU_B_UCSZ2 2
`define SRU_B_RXB8 1
`define SRU_C_SYNC 6
`define SRU_C_UPM1 5
`define SRU_C_UPM0 4
`define SRU_C_USBS 3
`define SRU_C_UCSZ_HI 2
`define SRU_C_UCSZ_LO 1

// ****************************************************************
// Reset values and sampling
// ****************************************************************
`define SRU_UCSZ_RST 2'h3
`define SRU_BAUD_RST 8'h00
`define SRU_SPB_NORM 5'h10
`define SRU_SPB_DBL 5'h08
`define SRU_VOTE_NORM 5'h08
`define SRU_VOTE_DBL 5'h04
`define SRU_VOTE_SPAN 5'h02
`define SRU_BUF_DEPTH 2'h2
`define SRU_DATA_MAX 4'h9

`endif

// *** common/sru_pkg.sv ***
// Types shared by the serial receive unit and its bench.
// Assumes sru_params.svh is on the include path.
package sru_pkg;
`include "sru_params.svh"

    typedef enum logic [3:0] {
        SRU_IDLE  = 4'b0001,
        SRU_START = 4'b0010,
        SRU_DATA  = 4'b0100,
        SRU_STOP  = 4'b1000
    } sru_rx_e;

    typedef struct packed {
        logic [`SRU_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sru_bus_s;

    typedef struct packed {
        logic [8:0] data;
        logic fe;
        logic dor;
        logic pe;
    } sru_entry_s;

    typedef struct packed {
        sru_rx_e fsm;
        logic [4:0] sc;
        logic [1:0] vote;
        logic lastSample;
        logic [3:0] bc;
        logic [8:0] sh;
        logic pbit;
        logic [7:0] baudCnt;
        logic xckPrev;
        sru_entry_s waitEnt;
        logic waitVld;
        logic lost;
        sru_entry_s [1:0] fifo;
        logic rdPtr;
        logic wrPtr;
        logic [1:0] cnt;
        logic rxen;
        logic rxcie;
        logic u2x;
        logic syncMode;
        logic upm1;
        logic upm0;
        logic usbs;
        logic [2:0] ucsz;
        logic [7:0] baud;
        logic [7:0] rdData;
    } sru_state_s;
endpackage

// *** hw/sru_receiver.sv ***
// Receive half of a serial port with a two-entry frame buffer.
// Assumes a single-cycle register port and pins synchronous to ref_clk.
//
// Overview of operation
// - Setting receive enable hands the serial input pin to the receiver.
// - Synchronous mode samples data on the external transfer clock.
// - Reception starts on a valid start bit; bits shift in until first stop.
// - Only the first stop bit is checked; a second one is ignored.
// - After the first stop bit the frame moves into the receive buffer.
// - Unused upper data bits read zero for characters under eight bits.
// - Nine-bit frames show the ninth bit in a status bit, read first.
// - Reading data advances the buffer; ninth bit and flags follow.
// - Receive complete is one while the buffer holds unread frames.
// - Clearing receive enable flushes the buffer and clears receive complete.
// - Disable acts at once, drops the frame and releases the pin.
// - Interrupt request stands while flag, enable and global enable are set.
// - Error flags are stored with their frame; status is read before data.
// - Writes never change error flags; software writes zeros there.
// - Error flags never raise an interrupt.
// - Framing error shows the first stop bit of the readable frame.
// - Overrun when buffer full, frame waiting and a new start is seen.
// - Overrun indication clears when a frame enters the buffer.
// - Parity check runs only with its enable bit; odd bit picks the sense.
// - Parity error marks a mismatch seen with checking on; else zero.
// - Sixteen samples per bit, eight in double speed.
// - Start bit kept by majority of samples 8, 9 and 10 (4, 5 and 6 in double speed); else rejected.
`timescale 1ns/1ps

module sru_receiver
    import sru_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire sru_bus_s bus,
    output logic [7:0] rdData,
    // Serial pins
    input wire logic serialInPin,
    input wire logic xckPin,
    output logic pinOverride,
    // Interrupt
    input wire logic globalIntEn,
    output logic rxIrq
);

    // ****************************************************************
    // State and combinational helpers
    // ****************************************************************
    sru_state_s st;
    sru_state_s nxt_st;

    logic pin;
    logic tick;
    logic xckRise;
    logic bitEvt;
    logic bitVal;
    logic startOk;
    logic frameDone;
    logic pop;
    logic push;
    logic [1:0] cntAfter;
    logic [3:0] nbits;
    logic [3:0] frameLen;
    logic [4:0] spb;
    logic [4:0] vFirst;
    logic [8:0] frameData;
    sru_entry_s doneEnt;
    sru_entry_s pushEnt;
    sru_entry_s head;
    logic [7:0] rv;
    logic busy;

    assign head = st.fifo[st.rdPtr];
    assign busy = (st.cnt != 2'h0);

    always_comb begin
        nxt_st = st;
        nxt_st.rdData = 8'h00;
        pin = st.rxen ? serialInPin : 1'b1;
        // Compare by range so lowering the divisor never stalls a full counter wrap
        tick = (st.baudCnt >= st.baud);
        xckRise = st.syncMode && xckPin && !st.xckPrev;
        bitEvt = 1'b0;
        bitVal = 1'b1;
        startOk = 1'b0;
        frameDone = 1'b0;
        push = 1'b0;
        pushEnt = st.waitEnt;
        doneEnt = '0;
        rv = 8'h00;
        // Reserved sizes fall back to eight bits
        case (st.ucsz)
            3'h0: nbits = 4'h5;
            3'h1: nbits = 4'h6;
            3'h2: nbits = 4'h7;
            3'h7: nbits = `SRU_DATA_MAX;
            default: nbits = 4'h8;
        endcase
        frameLen = nbits + {3'h0, st.upm1};
        spb = st.u2x ? `SRU_SPB_DBL : `SRU_SPB_NORM;
        vFirst = st.u2x ? `SRU_VOTE_DBL : `SRU_VOTE_NORM;
        nxt_st.xckPrev = xckPin;
        nxt_st.baudCnt = tick ? 8'h00 : st.baudCnt + 8'h01;
        if (tick) begin
            nxt_st.lastSample = pin;
        end

        // ****************************************************************
        // Bit sampling
        // ****************************************************************
        if (st.syncMode) begin
            bitEvt = xckRise && (st.fsm != SRU_IDLE);
            bitVal = pin;
        end else if (tick && (st.fsm != SRU_IDLE)) begin
            if (st.sc >= vFirst && st.sc < vFirst + `SRU_VOTE_SPAN) begin
                nxt_st.vote = {st.vote[0], pin};
            end
            if (st.sc == vFirst + `SRU_VOTE_SPAN) begin
                bitEvt = 1'b1;
                bitVal = (st.vote[1] & st.vote[0]) | (st.vote[1] & pin)
                    | (st.vote[0] & pin);
            end
            nxt_st.sc = (st.sc == spb) ? 5'h01 : st.sc + 5'h01;
        end

        // ****************************************************************
        // Frame sequencer
        // ****************************************************************
        case (st.fsm)
            SRU_IDLE: begin
                if (st.syncMode) begin
                    if (xckRise && !pin) begin
                        nxt_st.fsm = SRU_DATA;
                        nxt_st.bc = 4'h0;
                        startOk = 1'b1;
                    end
                end else if (tick && st.lastSample && !pin) begin
                    // This sample is number one of the start bit
                    nxt_st.fsm = SRU_START;
                    nxt_st.sc = 5'h02;
                end
            end
            SRU_START: begin
                if (bitEvt) begin
                    if (bitVal) begin
                        nxt_st.fsm = SRU_IDLE;
                    end else begin
                        nxt_st.fsm = SRU_DATA;
                        nxt_st.bc = 4'h0;
                        startOk = 1'b1;
                    end
                end
            end
            SRU_DATA: begin
                if (bitEvt) begin
                    if (st.bc < nbits) begin
                        nxt_st.sh = {bitVal, st.sh[8:1]};
                    end else begin
                        nxt_st.pbit = bitVal;
                    end
                    nxt_st.bc = st.bc + 4'h1;
                    if (st.bc + 4'h1 == frameLen) begin
                        nxt_st.fsm = SRU_STOP;
                    end
                end
            end
            SRU_STOP: begin
                if (bitEvt) begin
                    // Back to idle at once: a second stop bit is never waited for
                    nxt_st.fsm = SRU_IDLE;
                    frameDone = 1'b1;
                end
            end
            default: nxt_st.fsm = SRU_IDLE;
        endcase

        // Data sits LSB first at the top of the shifter; align it down
        frameData = st.sh >> (`SRU_DATA_MAX - nbits);
        doneEnt.data = frameData;
        doneEnt.fe = !bitVal;
        doneEnt.pe = st.upm1 && (st.pbit ^ (^frameData) ^ st.upm0);

        // ****************************************************************
        // Receive buffer
        // ****************************************************************
        pop = bus.rd && (bus.addr == `SRU_OFS_DATA) && busy;
        cntAfter = st.cnt - {1'b0, pop};
        if (st.waitVld && cntAfter < `SRU_BUF_DEPTH) begin
            push = 1'b1;
            pushEnt = st.waitEnt;
            nxt_st.waitVld = 1'b0;
        end
        if (frameDone) begin
            if (!push && !st.waitVld && cntAfter < `SRU_BUF_DEPTH) begin
                push = 1'b1;
                pushEnt = doneEnt;
            end else begin
                nxt_st.waitEnt = doneEnt;
                nxt_st.waitVld = 1'b1;
            end
        end
        if (startOk && st.waitVld && cntAfter == `SRU_BUF_DEPTH) begin
            // Shifter is about to be reused; the waiting frame is lost
            nxt_st.waitVld = 1'b0;
            nxt_st.lost = 1'b1;
        end
        if (push) begin
            pushEnt.dor = st.lost;
            nxt_st.fifo[st.wrPtr] = pushEnt;
            nxt_st.wrPtr = !st.wrPtr;
            nxt_st.lost = 1'b0;
        end
        nxt_st.rdPtr = st.rdPtr ^ pop;
        nxt_st.cnt = cntAfter + {1'b0, push};

        // ****************************************************************
        // Register writes
        // ****************************************************************
        if (bus.wr) begin
            case (bus.addr)
                `SRU_OFS_CSRA: begin
                    // Error flag positions are read-only
                    nxt_st.u2x = bus.wdata[`SRU_A_U2X];
                end
                `SRU_OFS_CSRB: begin
                    nxt_st.rxcie = bus.wdata[`SRU_B_RXCIE];
                    nxt_st.rxen = bus.wdata[`SRU_B_RXEN];
                    nxt_st.ucsz[2] = bus.wdata[`SRU_B_UCSZ2];
                end
                `SRU_OFS_CSRC: begin
                    nxt_st.syncMode = bus.wdata[`SRU_C_SYNC];
                    nxt_st.upm1 = bus.wdata[`SRU_C_UPM1];
                    nxt_st.upm0 = bus.wdata[`SRU_C_UPM0];
                    nxt_st.usbs = bus.wdata[`SRU_C_USBS];
                    nxt_st.ucsz[1:0] = bus.wdata[`SRU_C_UCSZ_HI:`SRU_C_UCSZ_LO];
                end
                `SRU_OFS_BAUD: nxt_st.baud = bus.wdata;
                default: ;
            endcase
        end

        // Disable overrides everything else in the same cycle
        if (!nxt_st.rxen) begin
            nxt_st.fsm = SRU_IDLE;
            nxt_st.cnt = 2'h0;
            nxt_st.rdPtr = 1'b0;
            nxt_st.wrPtr = 1'b0;
            nxt_st.waitVld = 1'b0;
            nxt_st.lost = 1'b0;
            nxt_st.lastSample = 1'b1;
            nxt_st.baudCnt = 8'h00;
        end

        // ****************************************************************
        // Register reads
        // ****************************************************************
        case (bus.addr)
            `SRU_OFS_DATA: rv = busy ? head.data[7:0] : 8'h00;
            `SRU_OFS_CSRA: begin
                rv[`SRU_A_RXC] = busy;
                rv[`SRU_A_FE] = busy && head.fe;
                rv[`SRU_A_DOR] = busy && head.dor;
                rv[`SRU_A_PE] = busy && head.pe;
                rv[`SRU_A_U2X] = st.u2x;
            end
            `SRU_OFS_CSRB: begin
                rv[`SRU_B_RXCIE] = st.rxcie;
                rv[`SRU_B_RXEN] = st.rxen;
                rv[`SRU_B_UCSZ2] = st.ucsz[2];
                rv[`SRU_B_RXB8] = busy && head.data[8];
            end
            `SRU_OFS_CSRC: begin
                rv[`SRU_C_SYNC] = st.syncMode;
                rv[`SRU_C_UPM1] = st.upm1;
                rv[`SRU_C_UPM0] = st.upm0;
                rv[`SRU_C_USBS] = st.usbs;
                rv[`SRU_C_UCSZ_HI:`SRU_C_UCSZ_LO] = st.ucsz[1:0];
            end
            `SRU_OFS_BAUD: rv = st.baud;
            default: rv = 8'h00;
        endcase
        if (bus.rd) begin
            nxt_st.rdData = rv;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.fsm <= SRU_IDLE;
            st.lastSample <= 1'b1;
            st.ucsz <= {1'b0, `SRU_UCSZ_RST};
            st.baud <= `SRU_BAUD_RST;
        end else begin
            st <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdData = st.rdData;
    assign pinOverride = st.rxen;
    // Only the buffer level feeds the request, never the error flags
    assign rxIrq = st.rxcie && globalIntEn && busy;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence seq_disable_write;
        bus.wr && bus.addr == `SRU_OFS_CSRB && !bus.wdata[`SRU_B_RXEN];
    endsequence

    sequence seq_start_reject;
        !st.syncMode && st.fsm == SRU_START && bitEvt && bitVal;
    endsequence

    sequence seq_data_read;
        bus.rd && bus.addr == `SRU_OFS_DATA && busy;
    endsequence

    a_flush_on_off: assert property (seq_disable_write |=> st.cnt == 2'h0 && !rdData[0] ##1
        !busy)
        else $error("buffer not flushed after disable");

    a_abort_frame: assert property (seq_disable_write |=> st.fsm == SRU_IDLE && !pinOverride)
        else $error("frame not abandoned on disable");

    a_start_noise: assert property (seq_start_reject |=> st.fsm == SRU_IDLE)
        else $error("noisy start bit not rejected");

    a_pop_advance: assert property (seq_data_read ##0 !push |=> st.cnt == $past(st.cnt) - 2'h1
        && st.rdPtr != $past(st.rdPtr))
        else $error("data read did not advance buffer");

    a_rxc_level: assert property (bus.rd && bus.addr == `SRU_OFS_CSRA |=>
        rdData[`SRU_A_RXC] == ($past(st.cnt) != 2'h0))
        else $error("receive complete does not match buffer");

    a_narrow_zero: assert property (bus.rd && bus.addr == `SRU_OFS_DATA && st.ucsz == 3'h0 |=>
        rdData[7:5] == 3'h0)
        else $error("upper bits not masked");

    a_irq_level: assert property (st.rxcie && globalIntEn && busy |-> rxIrq)
        else $error("interrupt request missing");

    a_irq_cause: assert property (rxIrq |-> busy && st.rxen)
        else $error("interrupt without buffered frame");

    a_frame_push: assert property (frameDone && !st.waitVld && !pop && st.cnt < 2'h2 |=>
        st.cnt == $past(st.cnt) + 2'h1 ##0 st.fifo[$past(st.wrPtr)].fe == !$past(bitVal))
        else $error("completed frame not stored");

    a_flags_ro: assert property (bus.wr && bus.addr == `SRU_OFS_CSRA && busy && !pop && st.rxen
        |=> $stable(head))
        else $error("status write changed stored flags");

    a_parity_off: assert property (push && !st.upm1 && !st.waitVld |=>
        !st.fifo[$past(st.wrPtr)].pe)
        else $error("parity error without checking");

    a_overrun_mark: assert property (startOk && st.waitVld && cntAfter == 2'h2 |=>
        st.lost ##0 !st.waitVld)
        else $error("overrun not recorded");

    a_overrun_clear: assert property (push && st.rxen |=> !st.lost || $past(startOk))
        else $error("overrun not cleared on transfer");

    a_sync_sample: assert property (st.syncMode && st.fsm == SRU_DATA && !xckRise |=>
        $stable(st.bc))
        else $error("sampled without transfer clock edge");

endmodule

// *** tb/sru_serial_tx.sv ***
// Behavioural serial transmitter driving the receiver's data and transfer clock pins.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps

module sru_serial_tx (
    // Clock
    input wire logic ref_clk,
    // Lines towards the receiver
    output logic txLine,
    output logic xckLine
);
    // The data line rests high between frames, as a pulled-up serial wire does
    initial begin
        txLine = 1'b1;
        xckLine = 1'b0;
    end

    // ********
    // One bit on the line
    // ********
    // Transfer clock rises mid-bit so the data has long settled when sampled
    task automatic bitOut(input logic v, input int spb, input logic sync);
        @(posedge ref_clk);
        txLine <= v;
        if (sync) begin
            repeat (3) @(posedge ref_clk);
            xckLine <= 1'b1;
            repeat (4) @(posedge ref_clk);
            xckLine <= 1'b0;
        end else begin
            repeat (spb - 1) @(posedge ref_clk);
        end
    endtask

    // ********
    // Frames and noise
    // ********
    task automatic sendFrame(input logic [8:0] d, input int nb, input logic parEn = 1'b0,
                             input logic parOdd = 1'b0, input logic parFlip = 1'b0,
                             input logic stopVal = 1'b1, input int spb = 16,
                             input logic sync = 1'b0);
        logic p;
        p = parOdd;
        bitOut(1'b0, spb, sync);
        for (int i = 0; i < nb; i++) begin
            bitOut(d[i], spb, sync);
            p = p ^ d[i];
        end
        if (parEn) begin
            bitOut(p ^ parFlip, spb, sync);
        end
        bitOut(stopVal, spb, sync);
        @(posedge ref_clk);
        txLine <= 1'b1;
    endtask

    task automatic glitch(input int n);
        @(posedge ref_clk);
        txLine <= 1'b0;
        repeat (n) @(posedge ref_clk);
        txLine <= 1'b1;
    endtask
endmodule

// *** tb/sru_receiver_bench.sv ***
// Self-checking bench for the serial receive unit: register tasks plus serial frames.
// Assumes sru_params.svh on the include path and the partner transmitter model.
`timescale 1ns/1ps
`include "sru_params.svh"

module sru_receiver_bench
    import sru_pkg::*;
;
    logic ref_clk;
    logic rst;
    sru_bus_s bus;
    logic [7:0] rdData;
    logic serialLine;
    logic xckLine;
    logic pinOverride;
    logic globalIntEn;
    logic rxIrq;
    int nFail;
    int nCompared;

    sru_receiver i_sru_receiver (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdData(rdData),
        .serialInPin(serialLine), .xckPin(xckLine), .pinOverride(pinOverride),
        .globalIntEn(globalIntEn), .rxIrq(rxIrq));
    sru_serial_tx i_sru_serial_tx (.ref_clk(ref_clk), .txLine(serialLine), .xckLine(xckLine));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ********
    // Register access and compares
    // ********
    task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdReg(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        v = rdData;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        nCompared++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic expRd(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rdReg(a, v);
        chk8(what, exp, v);
    endtask

    task automatic results();
        if (nFail == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well inside the cycle budget
    initial begin
        repeat (90000) @(posedge ref_clk);
        nFail++;
        $display("mismatch watchdog expected %h seen %h", 1'b0, 1'b1);
        results();
    end

    // ********
    // Main sequence
    // ********
    initial begin
        nFail = 0;
        nCompared = 0;
        bus = '0;
        rst = 1'b1;
        globalIntEn = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        globalIntEn <= 1'b1;
        chk1("pinOverride", 1'b0, pinOverride);
        expRd(`SRU_OFS_CSRA, 8'h00, "csra");
        expRd(`SRU_OFS_CSRB, 8'h00, "csrb");
        expRd(`SRU_OFS_CSRC, 8'h06, "csrc");
        expRd(3'h5, 8'h00, "unmapped");
        wrReg(`SRU_OFS_CSRB, 8'h90);
        chk1("pinOverride", 1'b1, pinOverride);
        i_sru_serial_tx.sendFrame(9'h0A5, 8);
        chk1("rxIrq", 1'b1, rxIrq);
        expRd(`SRU_OFS_CSRA, 8'h80, "csra");
        expRd(`SRU_OFS_DATA, 8'hA5, "data");
        chk1("rxIrq", 1'b0, rxIrq);
        // Four frames unread: third is lost when the fourth start arrives
        for (int k = 1; k < 5; k++) begin
            i_sru_serial_tx.sendFrame(9'(k * 8'h11), 8);
        end
        expRd(`SRU_OFS_CSRA, 8'h80, "csra");
        expRd(`SRU_OFS_DATA, 8'h11, "data");
        expRd(`SRU_OFS_CSRA, 8'h80, "csra");
        expRd(`SRU_OFS_DATA, 8'h22, "data");
        expRd(`SRU_OFS_CSRA, 8'h88, "csra");
        expRd(`SRU_OFS_DATA, 8'h44, "data");
        expRd(`SRU_OFS_CSRA, 8'h00, "csra");
        i_sru_serial_tx.sendFrame(9'h055, 8);
        expRd(`SRU_OFS_CSRA, 8'h80, "csra");
        expRd(`SRU_OFS_DATA, 8'h55, "data");
        // Two stop bits selected; only the first one decides the framing flag
        wrReg(`SRU_OFS_CSRC, 8'h0E);
        i_sru_serial_tx.sendFrame(9'h05A, 8, 1'b0, 1'b0, 1'b0, 1'b0);
        expRd(`SRU_OFS_CSRA, 8'h90, "csra");
        wrReg(`SRU_OFS_CSRA, 8'h00);
        expRd(`SRU_OFS_CSRA, 8'h90, "csra");
        wrReg(`SRU_OFS_CSRB, 8'h10);
        chk1("rxIrq", 1'b0, rxIrq);
        wrReg(`SRU_OFS_CSRB, 8'h90);
        expRd(`SRU_OFS_DATA, 8'h5A, "data");
        // Even and odd checking, each with a good and a bad parity bit
        for (int k = 0; k < 4; k++) begin
            wrReg(`SRU_OFS_CSRC, 8'h26 | {3'b000, k[1], 4'h0});
            i_sru_serial_tx.sendFrame(9'h037, 8, 1'b1, k[1], k[0]);
            expRd(`SRU_OFS_CSRA, 8'h80 | {5'b00000, k[0], 2'b00}, "csra");
            expRd(`SRU_OFS_DATA, 8'h37, "data");
        end
        for (int k = 0; k < 3; k++) begin
            wrReg(`SRU_OFS_CSRC, {5'b00000, k[1:0], 1'b0});
            i_sru_serial_tx.sendFrame(9'h1FF, 5 + k);
            expRd(`SRU_OFS_DATA, 8'(8'hFF >> (3 - k)), "narrow data");
        end
        wrReg(`SRU_OFS_CSRC, 8'h06);
        wrReg(`SRU_OFS_CSRB, 8'h94);
        i_sru_serial_tx.sendFrame(9'h1A5, 9);
        i_sru_serial_tx.sendFrame(9'h05A, 9);
        expRd(`SRU_OFS_CSRB, 8'h96, "csrb");
        expRd(`SRU_OFS_DATA, 8'hA5, "data");
        expRd(`SRU_OFS_CSRB, 8'h94, "csrb");
        expRd(`SRU_OFS_DATA, 8'h5A, "data");
        wrReg(`SRU_OFS_CSRB, 8'h90);
        // Low for samples 1 to 8 only: votes 9 and 10 see high
        i_sru_serial_tx.glitch(8);
        repeat (40) @(posedge ref_clk);
        expRd(`SRU_OFS_CSRA, 8'h00, "csra");
        wrReg(`SRU_OFS_CSRA, 8'h02);
        i_sru_serial_tx.sendFrame(9'h03C, 8, 1'b0, 1'b0, 1'b0, 1'b1, 8);
        expRd(`SRU_OFS_CSRA, 8'h82, "csra");
        expRd(`SRU_OFS_DATA, 8'h3C, "data");
        wrReg(`SRU_OFS_CSRA, 8'h00);
        wrReg(`SRU_OFS_CSRC, 8'h46);
        i_sru_serial_tx.sendFrame(9'h0C3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b1);
        expRd(`SRU_OFS_DATA, 8'hC3, "sync data");
        wrReg(`SRU_OFS_CSRC, 8'h06);
        // Divisor of two: one sample every second cycle, 32 cycles a bit
        wrReg(`SRU_OFS_BAUD, 8'h01);
        expRd(`SRU_OFS_BAUD, 8'h01, "baud");
        i_sru_serial_tx.sendFrame(9'h069, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
        expRd(`SRU_OFS_DATA, 8'h69, "slow data");
        wrReg(`SRU_OFS_BAUD, 8'h00);
        i_sru_serial_tx.sendFrame(9'h077, 8);
        wrReg(`SRU_OFS_CSRB, 8'h80);
        chk1("pinOverride", 1'b0, pinOverride);
        chk1("rxIrq", 1'b0, rxIrq);
        expRd(`SRU_OFS_CSRA, 8'h00, "csra");
        wrReg(`SRU_OFS_CSRB, 8'h90);
        expRd(`SRU_OFS_DATA, 8'h00, "data");
        // Disable in mid-frame: the partial frame must never appear
        fork
            i_sru_serial_tx.sendFrame(9'h000, 8);
            begin
                repeat (40) @(posedge ref_clk);
                wrReg(`SRU_OFS_CSRB, 8'h80);
            end
        join
        wrReg(`SRU_OFS_CSRB, 8'h90);
        expRd(`SRU_OFS_CSRA, 8'h00, "csra");
        results();
    end
endmodule
